// >>> hdl/dfs_pkg.sv
// package: constants, fault classes, register map and states of the fault/status supervisor
package dfs_pkg;

    // ------------------------------------------------------------
    // fault codes
    // ------------------------------------------------------------
    localparam int unsigned NUM_CODES  = 100;
    localparam int unsigned CODE_W     = 7;
    localparam int unsigned VOLT_W     = 12;

    // class tables, one bit per fault code
    localparam logic [NUM_CODES-1:0] WARN_CLASS  = 100'h00000003fe0000784001e3ff6;
    localparam logic [NUM_CODES-1:0] ALARM_CLASS = 100'h80000000090000025e047ff94;
    localparam logic [NUM_CODES-1:0] LOCK_CLASS  = 100'h800000000000000200001e010;

    // codes raised by the supervisor's own comparators
    localparam int unsigned CODE_LIVE_ZERO = 2;
    localparam int unsigned CODE_BUS_HIGH  = 5;
    localparam int unsigned CODE_BUS_LOW   = 6;
    localparam int unsigned CODE_BUS_OV    = 7;
    localparam int unsigned CODE_BUS_UV    = 8;
    localparam int unsigned CODE_INV_OVL   = 9;

    // ------------------------------------------------------------
    // bus voltage limits in volts dc, indexed by supply class
    // ------------------------------------------------------------
    localparam logic [1:0]        SUPPLY_CLS_MAX = 2'h2;
    localparam logic [VOLT_W-1:0] UNDERVOLT_LIM [0:2] = '{12'h0d3, 12'h192, 12'h22d};
    localparam logic [VOLT_W-1:0] WARN_LOW_LIM  [0:2] = '{12'h0de, 12'h1a7, 12'h249};
    localparam logic [VOLT_W-1:0] WARN_HIGH_LIM [0:2] = '{12'h180, 12'h2fa, 12'h3af};
    localparam logic [VOLT_W-1:0] OVERVOLT_LIM  [0:2] = '{12'h1a9, 12'h31e, 12'h3cf};

    // ------------------------------------------------------------
    // inverter overload thresholds, percent of full scale
    // ------------------------------------------------------------
    localparam int unsigned OVL_WARN_PCT  = 98;
    localparam int unsigned OVL_TRIP_PCT  = 100;
    localparam int unsigned OVL_RESET_PCT = 90;
    localparam int unsigned OVL_FULL_CNT  = 1000000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned CYC_PER_MS      = 1000000 / CLK_PERIOD_NS;
    localparam int unsigned ESC_TIME_MS     = 1000;
    localparam int unsigned TRIP_DLY_MS     = 5;
    localparam int unsigned FLASH_TIME_MS   = 250;
    localparam int unsigned AUTO_RST_TIME_MS = 1000;

    // ------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_CMD     = 8'h04;
    localparam logic [7:0] REG_AIN_MIN = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0c;
    localparam logic [7:0] REG_OVL     = 8'h10;
    localparam logic [7:0] REG_DISP    = 8'h14;

    localparam int unsigned CTRL_AUTO_BIT      = 0;
    localparam int unsigned CTRL_PROFILE_BIT   = 1;
    localparam int unsigned CTRL_WARN_ONLY_BIT = 2;
    localparam int unsigned CTRL_COAST_BIT     = 3;
    localparam int unsigned CTRL_CLS_LSB       = 4;
    localparam logic [7:0]  CTRL_RESET         = 8'h00;

    localparam int unsigned CMD_RESET_BIT = 0;
    localparam int unsigned CMD_STOP_BIT  = 1;
    localparam int unsigned CMD_START_BIT = 2;

    // display mode codes
    localparam logic [1:0] DISP_NONE   = 2'h0;
    localparam logic [1:0] DISP_WARN   = 2'h1;
    localparam logic [1:0] DISP_ALARM  = 2'h2;
    localparam logic [1:0] DISP_LOCKED = 2'h3;

    // ------------------------------------------------------------
    // operating status
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_NOT_READY  = 7'h01,
        ST_START_INH  = 7'h02,
        ST_COAST_INH  = 7'h04,
        ST_ADAPT_DONE = 7'h08,
        ST_STANDBY    = 7'h10,
        ST_STOP       = 7'h20,
        ST_RUN        = 7'h40
    } dfs_state_t;

endpackage

// >>> hdl/dfs_pick_if.sv
// interface: request vector in, lowest set code out
interface dfs_pick_if
    import dfs_pkg::*;
#(
    parameter int unsigned N = NUM_CODES
);
    logic [N-1:0]      req;
    logic              hit;
    logic [CODE_W-1:0] code;

    modport src  (output req, input  hit, input  code);
    modport pick (input  req, output hit, output code);
endinterface

// >>> hdl/dfs_prio_pick.sv
// priority picker: lowest numbered active fault code
module dfs_prio_pick
    import dfs_pkg::*;
(
    dfs_pick_if.pick p
);
    always_comb
    begin
        p.hit  = 1'b0;
        p.code = '0;
        for (int i = NUM_CODES - 1; i >= 0; i--)
        begin
            if (p.req[i])
            begin
                p.hit  = 1'b1;
                p.code = CODE_W'(i);
            end
        end
    end
endmodule

// >>> hdl/dfs_supervisor.sv
// drive fault and status supervisor with wishbone register slave
//
// Our own choices: the register offsets and the Wishbone slave port.
module dfs_supervisor
    import dfs_pkg::*;
#(
    parameter int unsigned ESC_CYC      = ESC_TIME_MS * CYC_PER_MS,
    parameter int unsigned TRIP_DLY_CYC = TRIP_DLY_MS * CYC_PER_MS,
    parameter int unsigned FLASH_CYC    = FLASH_TIME_MS * CYC_PER_MS,
    parameter int unsigned AUTO_RST_CYC = AUTO_RST_TIME_MS * CYC_PER_MS,
    parameter int unsigned OVL_FULL     = OVL_FULL_CNT
)
(
    // clock, reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // pins from panel, terminals and power stage
    input  wire logic [NUM_CODES-1:0] fault_i,
    input  wire logic                 reset_key_i,
    input  wire logic                 reset_di_i,
    input  wire logic                 stop_key_i,
    input  wire logic                 stop_di_i,
    input  wire logic                 start_di_i,
    input  wire logic                 coast_n_i,
    input  wire logic                 off_command_first_n_i,
    input  wire logic                 off_command_second_n_i,
    input  wire logic                 off_command_third_n_i,
    // measurements on this clock
    input  wire logic [VOLT_W-1:0]    bus_voltage_i,
    input  wire logic [15:0]          ain_value_i,
    input  wire logic                 inv_overcurrent_i,
    input  wire logic                 adaptation_done_i,
    // motor control
    output logic                      motor_run_o,
    output logic                      motor_coast_o,
    // display and indicators
    output logic [6:0]                status_o,
    output logic [1:0]                disp_mode_o,
    output logic [CODE_W-1:0]         disp_line1_code_o,
    output logic [CODE_W-1:0]         disp_line2_code_o,
    output logic                      disp_line2_flash_o,
    output logic [CODE_W-1:0]         disp_line34_code_o,
    output logic [VOLT_W-1:0]         disp_voltage_o,
    output logic                      disp_voltage_show_o,
    output logic                      alarm_led_o,
    output logic                      warn_led_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int unsigned SYNC_W = NUM_CODES + 9;
    localparam int unsigned OVL_W  = $clog2(OVL_FULL + 1);
    localparam logic [OVL_W-1:0] OVL_MAX      = OVL_W'(OVL_FULL);
    localparam logic [OVL_W-1:0] OVL_WARN_CNT = OVL_W'((64'(OVL_FULL) * OVL_WARN_PCT) / 100);
    localparam logic [OVL_W-1:0] OVL_TRIP_CNT = OVL_W'((64'(OVL_FULL) * OVL_TRIP_PCT) / 100);
    localparam logic [OVL_W-1:0] OVL_RST_CNT  = OVL_W'((64'(OVL_FULL) * OVL_RESET_PCT) / 100);

    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] prev_q;
    wire  [SYNC_W-1:0] pin_vec = {fault_i, reset_key_i, reset_di_i, stop_key_i, stop_di_i, start_di_i,
                                  coast_n_i, off_command_first_n_i, off_command_second_n_i,
                                  off_command_third_n_i};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else if (ce_i)
        begin
            meta_q <= pin_vec;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    wire [SYNC_W-1:0]    pin_rise  = sync_q & ~prev_q;
    wire [NUM_CODES-1:0] ext_fault = sync_q[SYNC_W-1:9];
    wire                 reset_pin = pin_rise[8] | pin_rise[7];
    wire                 stop_pin  = pin_rise[6] | pin_rise[5];
    wire                 start_pin = pin_rise[4];
    wire                 coast_n   = sync_q[3];
    wire                 off_command_first_n    = sync_q[2];
    wire                 off_command_second_n    = sync_q[1];
    wire                 off_command_third_n    = sync_q[0];

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic [15:0] ain_min_q;
    logic [31:0] rd_mux;

    wire       wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wb_wr    = wb_hit & wb_we_i;
    wire [7:0] wb_word  = {wb_adr_i[7:2], 2'b00};
    wire       wr_ctrl  = wb_wr & (wb_word == REG_CTRL) & wb_sel_i[0];
    wire       wr_cmd   = wb_wr & (wb_word == REG_CMD) & wb_sel_i[0];
    wire       wr_ain   = wb_wr & (wb_word == REG_AIN_MIN);
    wire       ser_rst  = wr_cmd & wb_dat_i[CMD_RESET_BIT];
    wire       ser_stop = wr_cmd & wb_dat_i[CMD_STOP_BIT];
    wire       ser_start = wr_cmd & wb_dat_i[CMD_START_BIT];

    wire       auto_en   = ctrl_q[CTRL_AUTO_BIT];
    wire       profile   = ctrl_q[CTRL_PROFILE_BIT];
    wire       warn_only = ctrl_q[CTRL_WARN_ONLY_BIT];
    wire       ser_coast = ctrl_q[CTRL_COAST_BIT];
    wire [1:0] cls_raw   = ctrl_q[CTRL_CLS_LSB +: 2];
    wire [1:0] cls       = (cls_raw > SUPPLY_CLS_MAX) ? SUPPLY_CLS_MAX : cls_raw;

    // ------------------------------------------------------------
    // own fault comparators
    // ------------------------------------------------------------
    logic [OVL_W-1:0]     ovl_q;
    logic [NUM_CODES-1:0] int_fault;

    wire live_zero = ain_value_i < (ain_min_q >> 1);
    wire bus_high  = bus_voltage_i > WARN_HIGH_LIM[cls];
    wire bus_low   = bus_voltage_i < WARN_LOW_LIM[cls];
    wire bus_ov    = bus_voltage_i > OVERVOLT_LIM[cls];
    wire bus_uv    = bus_voltage_i < UNDERVOLT_LIM[cls];
    wire ovl_warn  = ovl_q >= OVL_WARN_CNT;
    wire ovl_trip  = ovl_q >= OVL_TRIP_CNT;
    wire ovl_ok    = ovl_q < OVL_RST_CNT;

    always_comb
    begin
        int_fault                 = '0;
        int_fault[CODE_LIVE_ZERO] = live_zero;
        int_fault[CODE_BUS_HIGH]  = bus_high;
        int_fault[CODE_BUS_LOW]   = bus_low;
        int_fault[CODE_BUS_OV]    = bus_ov;
        int_fault[CODE_BUS_UV]    = bus_uv;
        int_fault[CODE_INV_OVL]   = ovl_warn;
    end

    // thermal counter climbs while overloaded and relaxes otherwise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ovl_q <= '0;
        else if (ce_i)
        begin
            if (inv_overcurrent_i && ovl_q < OVL_MAX)
                ovl_q <= ovl_q + OVL_W'(1);
            else if (!inv_overcurrent_i && ovl_q != '0)
                ovl_q <= ovl_q - OVL_W'(1);
        end
    end

    // ------------------------------------------------------------
    // per-code classification and escalation
    // ------------------------------------------------------------
    wire  [NUM_CODES-1:0] cond = ext_fault | int_fault;
    logic [NUM_CODES-1:0] esc;
    logic [NUM_CODES-1:0] alarm_q;
    logic [NUM_CODES-1:0] lock_q;

    for (genvar c = 0; c < NUM_CODES; c++)
    begin : g_code
        if (c == CODE_INV_OVL)
        begin : g_ovl
            assign esc[c] = ovl_trip;
        end
        else if (WARN_CLASS[c] && ALARM_CLASS[c])
        begin : g_both
            // overvoltage and undervoltage use the unit trip delay, others the escalation delay
            localparam int unsigned LIM = (c == CODE_BUS_OV || c == CODE_BUS_UV) ? TRIP_DLY_CYC : ESC_CYC;
            logic [31:0] cnt_q;
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    cnt_q <= '0;
                else if (ce_i)
                    cnt_q <= !cond[c] ? '0 : (cnt_q == LIM) ? cnt_q : cnt_q + 32'h1;
            end
            // locked codes always escalate; the setting only keeps ordinary ones as warnings
            assign esc[c] = cond[c] & (cnt_q == LIM) & (LOCK_CLASS[c] | ~warn_only);
        end
        else
        begin : g_single
            assign esc[c] = cond[c] & ALARM_CLASS[c];
        end
    end

    wire [NUM_CODES-1:0] warn_act  = cond & WARN_CLASS & ~alarm_q;
    wire                 trip      = |alarm_q;
    wire                 locked    = |lock_q;
    wire                 fault_now = |(alarm_q & cond);

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    logic [31:0] auto_cnt_q;

    wire auto_evt  = auto_en & (auto_cnt_q == AUTO_RST_CYC);
    wire reset_evt = reset_pin | ser_rst | auto_evt;
    wire rst_take  = reset_evt & ~locked & ovl_ok;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            auto_cnt_q <= '0;
        else if (ce_i)
            auto_cnt_q <= (!auto_en || !trip || fault_now || auto_evt) ? '0 : auto_cnt_q + 32'h1;
    end

    // new faults win over a reset in the same cycle; only power-up clears a lock
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            alarm_q <= '0;
            lock_q  <= '0;
        end
        else if (ce_i)
        begin
            alarm_q <= esc | (alarm_q & ~({NUM_CODES{rst_take}} & ~lock_q));
            lock_q  <= lock_q | (esc & LOCK_CLASS);
        end
    end

    // ------------------------------------------------------------
    // operating status
    // ------------------------------------------------------------
    dfs_state_t state_q;
    dfs_state_t state_d;

    wire stop_evt  = stop_pin | ser_stop;
    wire start_evt = start_pin | ser_start;
    wire adapt_evt = adaptation_done_i;

    always_comb
    begin
        state_d = state_q;
        if (trip || !off_command_first_n)
            state_d = ST_NOT_READY;
        else if (!off_command_second_n || !off_command_third_n)
            state_d = profile ? ST_START_INH : ST_NOT_READY;
        else if (!coast_n || ser_coast)
            state_d = ST_COAST_INH;
        else if (adapt_evt)
            state_d = ST_ADAPT_DONE;
        else
        begin
            unique case (state_q)
                ST_NOT_READY,
                ST_START_INH,
                ST_COAST_INH:  state_d = ST_STANDBY;
                ST_ADAPT_DONE: state_d = reset_evt ? ST_RUN : ST_ADAPT_DONE;
                ST_STANDBY,
                ST_STOP:       state_d = start_evt ? ST_RUN : state_q;
                ST_RUN:        state_d = stop_evt ? ST_STOP : ST_RUN;
                default:       state_d = ST_NOT_READY;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_q <= ST_NOT_READY;
        else if (ce_i)
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // display selection
    // ------------------------------------------------------------
    dfs_pick_if lock_pick ();
    dfs_pick_if alarm_pick ();
    dfs_pick_if warn_pick ();

    assign lock_pick.req  = alarm_q & lock_q;
    assign alarm_pick.req = alarm_q;
    assign warn_pick.req  = warn_act;

    dfs_prio_pick u_lock_pick  (.p(lock_pick));
    dfs_prio_pick u_alarm_pick (.p(alarm_pick));
    dfs_prio_pick u_warn_pick  (.p(warn_pick));

    logic [31:0] flash_cnt_q;
    logic        flash_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flash_cnt_q <= '0;
            flash_q     <= 1'b0;
        end
        else if (ce_i)
        begin
            flash_cnt_q <= (flash_cnt_q == FLASH_CYC) ? '0 : flash_cnt_q + 32'h1;
            flash_q     <= flash_q ^ (flash_cnt_q == FLASH_CYC);
        end
    end

    wire [1:0] mode_d = lock_pick.hit  ? DISP_LOCKED :
                        alarm_pick.hit ? DISP_ALARM  :
                        warn_pick.hit  ? DISP_WARN   : DISP_NONE;
    wire [CODE_W-1:0] alarm_code = lock_pick.hit ? lock_pick.code : alarm_pick.code;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            disp_mode_o         <= DISP_NONE;
            disp_line1_code_o   <= '0;
            disp_line2_code_o   <= '0;
            disp_line2_flash_o  <= 1'b0;
            disp_line34_code_o  <= '0;
            disp_voltage_o      <= '0;
            disp_voltage_show_o <= 1'b0;
            alarm_led_o         <= 1'b0;
            warn_led_o          <= 1'b0;
            motor_run_o         <= 1'b0;
            motor_coast_o       <= 1'b1;
        end
        else if (ce_i)
        begin
            disp_mode_o         <= mode_d;
            disp_line1_code_o   <= warn_pick.code;
            disp_line2_code_o   <= alarm_pick.hit ? alarm_code : warn_pick.code;
            disp_line2_flash_o  <= !alarm_pick.hit && warn_pick.hit && flash_q;
            disp_line34_code_o  <= alarm_pick.hit ? alarm_code : '0;
            disp_voltage_o      <= bus_voltage_i;
            disp_voltage_show_o <= alarm_q[CODE_BUS_UV];
            alarm_led_o         <= trip & flash_q;
            warn_led_o          <= flash_q & (trip ? fault_now : warn_pick.hit);
            motor_run_o         <= (state_d == ST_RUN);
            motor_coast_o       <= trip | (state_d != ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // wishbone registers
    // ------------------------------------------------------------
    // unmapped words still ack and read zero so a stray access never hangs the master
    assign rd_mux = (wb_word == REG_CTRL)    ? {24'h000000, ctrl_q} :
                    (wb_word == REG_AIN_MIN) ? {16'h0000, ain_min_q} :
                    (wb_word == REG_STATUS)  ? {21'h000000, ~ovl_ok, locked, trip, |warn_act, 7'(state_q)} :
                    (wb_word == REG_OVL)     ? 32'(ovl_q) :
                    (wb_word == REG_DISP)    ? {7'h00, disp_line34_code_o, 1'b0, disp_line2_code_o,
                                                1'b0, disp_line1_code_o, disp_mode_o} :
                    32'h00000000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q    <= CTRL_RESET;
            ain_min_q <= '0;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= '0;
        end
        else if (ce_i)
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= rd_mux;
            if (wr_ctrl)
                ctrl_q <= wb_dat_i[7:0];
            if (wr_ain && wb_sel_i[0])
                ain_min_q[7:0] <= wb_dat_i[7:0];
            if (wr_ain && wb_sel_i[1])
                ain_min_q[15:8] <= wb_dat_i[15:8];
        end
    end

    assign status_o = state_q;

endmodule

// >>> dv/dfs_panel.sv
// partner model: panel keys and digital inputs, each press held high
module dfs_panel (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [4:0] cmd_i,
    input  wire logic       slow_i,
    output logic      [4:0] pin_o
);
    logic [3:0] cnt_q;
    // a press outlasts the pin synchronisers, a slow one much longer
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (cnt_q == 4'h0 && cmd_i == 5'h0))
            pin_o <= 5'h0;
        else if (cmd_i != 5'h0)
            pin_o <= cmd_i;
        cnt_q <= rst_i ? 4'h0 : cmd_i != 5'h0 ? (slow_i ? 4'hc : 4'h4) : cnt_q - 4'(cnt_q != 4'h0);
    end
endmodule

// >>> dv/dfs_props.sv
// checker: port assertions of the fault and status supervisor
module dfs_props
    import dfs_pkg::*;
(
    input wire logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_ack_o, motor_run_o, motor_coast_o,
    input wire logic off_command_first_n_i, adaptation_done_i, alarm_led_o, warn_led_o, disp_line2_flash_o,
    input wire logic [6:0]        status_o,
    input wire logic [1:0]        disp_mode_o,
    input wire logic [CODE_W-1:0] disp_line2_code_o, disp_line34_code_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_one_cycle_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    run_no_coast_a: assert property (motor_run_o |-> !motor_coast_o)
        else $error("running while coasting");
    trip_coast_a: assert property (disp_mode_o[1] |-> motor_coast_o)
        else $error("trip without coast");
    alarm_led_a: assert property (alarm_led_o |-> disp_mode_o[1])
        else $error("alarm led without alarm");
    quiet_leds_a: assert property (disp_mode_o == DISP_NONE |-> !alarm_led_o && !warn_led_o)
        else $error("led lit without fault");
    warn_flash_a: assert property (disp_line2_flash_o |-> disp_mode_o == DISP_WARN)
        else $error("line 2 flashing outside warning");
    alarm_lines_a: assert property (disp_mode_o == DISP_ALARM |-> disp_line34_code_o == disp_line2_code_o)
        else $error("alarm lines disagree");
    lock_hold_a: assert property (disp_mode_o == DISP_LOCKED |=> disp_mode_o == DISP_LOCKED)
        else $error("lock cleared without power cycle");
    off_not_ready_a: assert property ((!off_command_first_n_i && ce_i) [*5] |-> status_o == ST_NOT_READY)
        else $error("off command low but not not-ready");
endmodule
bind dfs_supervisor dfs_props chk (.*);

// >>> dv/drive_fault_status_supervisor_test.sv
// testbench: panel, pin and wishbone stimulus with self-checks
module drive_fault_status_supervisor_test import dfs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_we_i = 0, coast_n_i = 1, inv_overcurrent_i = 0, slow = 0;
    logic adaptation_done_i = 0;
    logic wb_ack_o, motor_run_o, motor_coast_o, alarm_led_o, warn_led_o, disp_line2_flash_o, disp_voltage_show_o;
    logic [7:0] wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rdat;
    logic [NUM_CODES-1:0] fault_i = '0;
    logic [VOLT_W-1:0] bus_voltage_i = 12'h12c, disp_voltage_o;
    logic [15:0] ain_value_i = 0;
    logic [4:0] cmd = 0, pin;
    logic [2:0] offn = 0;
    logic [6:0] status_o, disp_line1_code_o, disp_line2_code_o, disp_line34_code_o;
    logic [1:0] disp_mode_o;
    int n_errors = 0, total_checks = 0, k, c, e;
    int cl[5] = '{22, 14, 1, 4, 0};
    int wl[15] = '{1, 19, 20, 39, 40, 41, 42, 61, 62, 64, 65, 66, 67, 68, 69};
    always #2.5 clk_i = ~clk_i;
    dfs_panel pnl (.clk_i, .rst_i, .cmd_i(cmd), .slow_i(slow), .pin_o(pin));
    dfs_supervisor #(.ESC_CYC(20), .TRIP_DLY_CYC(10), .FLASH_CYC(4), .AUTO_RST_CYC(30), .OVL_FULL(100)) dut (.*,
        .ce_i(1'b1), .wb_stb_i(wb_cyc_i), .wb_sel_i(4'hf), .reset_key_i(pin[0]), .reset_di_i(pin[1]),
        .stop_key_i(pin[2]), .stop_di_i(pin[3]), .start_di_i(pin[4]), .off_command_first_n_i(offn[0]),
        .off_command_second_n_i(offn[1]), .off_command_third_n_i(offn[2]));
    task end_sim;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cy(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // leds flash, so collect {alarm, warning, line 2 flash} over one full on/off flash period of 10 cycles
    task leds(input logic [2:0] ex);
        logic [2:0] m;
        m = 0;
        repeat (10)
        begin
            cy(1);
            m |= {alarm_led_o, warn_led_o, disp_line2_flash_o};
        end
        chk(m, ex);
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        wb_cyc_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++i < 20);
        rdat = wb_dat_o;
        wb_cyc_i <= 0;
        if (i >= 20)
        begin
            n_errors++;
            end_sim();
        end
        cy(1);
    endtask
    task pr(input logic [4:0] m);
        slow <= 1'($urandom);
        cmd <= m;
        cy(1);
        cmd <= 0;
        cy(16);
    endtask
    // expected display class of a fault code
    function logic [1:0] exp_mode(input int f);
        if (f inside {4, 13, 14, 15, 16, 37, 99}) return DISP_LOCKED;
        if (f inside {22, 29, 30, 31, 32, 60}) return DISP_ALARM;
        return DISP_WARN;
    endfunction
    initial
    begin
        void'($urandom(60597));
        cy(2);
        rst_i <= 0;
        offn <= 3'h7;
        cy(6);
        wb(0, 8'h3c, 32'h5a);
        chk(rdat, 0);
        pr(5'h10);
        chk({motor_run_o, status_o}, {1'b1, ST_RUN});
        pr(5'h04 << $urandom % 2);
        chk(status_o, ST_STOP);
        wb(1, REG_CTRL, 32'h2);
        offn <= 3'h5;
        cy(6);
        chk(status_o, ST_START_INH);
        offn <= 3'h7;
        wb(1, REG_CTRL, 32'h0);
        cl[4] = wl[$urandom % 15];
        for (k = 0; k < 5; k++)
        begin
            c = cl[k];
            e = exp_mode(c) == DISP_WARN ? 0 : c;
            bus_voltage_i <= 12'(223 + $urandom % 161);
            ain_value_i <= 16'($urandom);
            fault_i[c] <= 1;
            fault_i[1] <= 1;
            cy(30);
            chk(disp_mode_o, exp_mode(c));
            chk({disp_line34_code_o, disp_line2_code_o, disp_line1_code_o}, {7'(e), 7'(e ? e : 1), 7'd1});
            leds({e != 0, 1'b1, e == 0});
            fault_i <= '0;
            cy(6);
            leds({e != 0, 2'b00});
            if (k % 3 == 2)
                wb(1, REG_CMD, 32'h1);
            else
                pr(5'(1 << k % 3));
            cy(6);
            chk(disp_mode_o, exp_mode(c) == DISP_LOCKED ? DISP_LOCKED : DISP_NONE);
            rst_i <= exp_mode(c) == DISP_LOCKED;
            cy(2);
            rst_i <= 0;
            cy(8);
            chk(status_o, ST_STANDBY);
        end
        bus_voltage_i <= 12'(150 + $urandom % 61);
        cy(16);
        chk({disp_voltage_show_o, disp_voltage_o, disp_line2_code_o, disp_line1_code_o},
            {1'b1, bus_voltage_i, 7'(CODE_BUS_UV), 7'(CODE_BUS_LOW)});
        bus_voltage_i <= 12'(426 + $urandom % 100);
        cy(16);
        chk({disp_line2_code_o, disp_line1_code_o}, {7'(CODE_BUS_OV), 7'(CODE_BUS_HIGH)});
        bus_voltage_i <= 12'h12c;
        wb(1, REG_CMD, 32'h1);
        ain_value_i <= 16'(16'h80 - $urandom % 2);
        wb(1, REG_AIN_MIN, 32'h100);
        cy(4);
        chk(disp_line1_code_o, ain_value_i < 16'h80 ? CODE_LIVE_ZERO : 0);
        ain_value_i <= 16'hffff;
        adaptation_done_i <= 1;
        cy(2);
        adaptation_done_i <= 0;
        cy(2);
        chk(status_o, ST_ADAPT_DONE);
        pr(5'h01 << $urandom % 2);
        chk({motor_run_o, status_o}, {1'b1, ST_RUN});
        coast_n_i <= 0;
        cy(5);
        chk({motor_coast_o, status_o}, {1'b1, ST_COAST_INH});
        coast_n_i <= 1;
        inv_overcurrent_i <= 1;
        cy(110);
        chk(disp_line2_code_o, CODE_INV_OVL);
        inv_overcurrent_i <= 0;
        wb(1, REG_CMD, 32'h1);
        cy(4);
        chk(disp_mode_o, DISP_ALARM);
        cy(20);
        wb(1, REG_CMD, 32'h1);
        cy(6);
        chk(disp_mode_o, DISP_NONE);
        end_sim();
    end
endmodule
